/* File: inc/sscp_pkg.sv */
// Shared constants and types for the select-gated serial configuration port
package sscp_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] SSCP_IDX_ADDR   = 8'h00;
  localparam logic [7:0] SSCP_IDX_RESET  = 8'h01;
  localparam logic [7:0] SSCP_IDX_PIN0   = 8'h02;
  localparam logic [7:0] SSCP_IDX_PINOUT = 8'h05;
  localparam logic [7:0] SSCP_IDX_OUTSEL = 8'h07;
  localparam logic [7:0] SSCP_NUM_REGS   = 8'h08;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SSCP_RST_ADDR   = 8'hAE;
  localparam logic [7:0] SSCP_RST_PIN    = 8'h05;
  localparam logic [7:0] SSCP_RST_ZERO   = 8'h00;
  localparam logic [7:0] SSCP_RST_OUTSEL = 8'h01;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int         SSCP_BIT_SWRST  = 0;
  localparam int         SSCP_BIT_ANAOFF = 4;
  localparam int         SSCP_BIT_OE     = 0;
  localparam int         SSCP_BIT_PRI    = 0;
  localparam int         SSCP_BIT_SEC    = 1;
  localparam logic [3:0] SSCP_MODE_GPOUT = 4'h0;
  localparam logic [7:0] SSCP_ANAOFF_MSK = 8'h10;
  localparam logic [2:0] SSCP_LAST_BIT   = 3'h7;

  typedef logic [7:0][7:0] sscp_regs_t;

  typedef enum logic [3:0] {
    SSCP_IDLE     = 4'b0000,
    SSCP_ADDR     = 4'b0001,
    SSCP_ACK_ADDR = 4'b0010,
    SSCP_INDEX    = 4'b0011,
    SSCP_ACK_IDX  = 4'b0100,
    SSCP_WDATA    = 4'b0101,
    SSCP_ACK_WR   = 4'b0110,
    SSCP_RDATA    = 4'b0111,
    SSCP_RACK     = 4'b1000
  } sscp_state_t;

  typedef struct packed {
    sscp_state_t st;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic        rw;
    logic [7:0]  idx;
    logic        drv;
    logic        wrTog;
    logic        prevRise;
    sscp_regs_t  regs;
  } sscp_link_t;

  typedef struct packed {
    logic togSeen;
    logic pin0;
    logic pin0Oe;
    logic anaOff;
    logic priEn;
    logic secEn;
  } sscp_sys_t;

endpackage

/* File: rtl/sscp_sync.sv */
// Two-flop level synchroniser
`timescale 1ns/1ps
module sscp_sync (
  input  wire logic clk,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule

/* File: rtl/sscp_port.sv */
// Select-gated serial configuration target with register file and system outputs
`timescale 1ns/1ps
module sscp_port
  import sscp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sck,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic busSelectIn,
  output logic      generalPinZero,
  output logic      generalPinZeroOe,
  output logic      analogDisable,
  output logic      serOutPrimaryEn,
  output logic      serOutSecondaryEn
);

  // ****************************************
  // Link domain
  // ****************************************
  logic       rstLink;
  logic       selLink;
  logic       sdaFall_r;
  logic       sdaOe_r;
  logic       start;
  logic [7:0] byteIn;
  logic [7:0] rdData;
  logic       lastBit;
  sscp_link_t l_r;
  sscp_link_t l_nxt;

  sscp_sync uRstLink (
    .clk (sck),
    .d   (rst),
    .q   (rstLink)
  );

  // Select is a pin; only the settled copy gates the engine
  sscp_sync uSelLink (
    .clk (sck),
    .d   (busSelectIn),
    .q   (selLink)
  );

  // Sampled at the falling edge so a START inside the high phase is visible
  always_ff @(negedge sck) begin
    sdaFall_r <= sdaIn;
  end

  assign start   = l_r.prevRise & ~sdaFall_r;
  assign byteIn  = {l_r.sh[6:0], sdaIn};
  assign lastBit = (l_r.cnt == SSCP_LAST_BIT);
  assign rdData  = (l_r.idx < SSCP_NUM_REGS) ? l_r.regs[l_r.idx[2:0]] : SSCP_RST_ZERO;

  function automatic sscp_regs_t defaults(input logic [7:0] id);
    sscp_regs_t r;
    r                = '0;
    r[SSCP_IDX_ADDR] = id;
    for (int i = SSCP_IDX_PIN0; i < SSCP_IDX_PINOUT; i++) begin
      r[i] = SSCP_RST_PIN;
    end
    r[SSCP_IDX_OUTSEL] = SSCP_RST_OUTSEL;
    return r;
  endfunction

  always_comb begin
    l_nxt          = l_r;
    l_nxt.prevRise = sdaIn;
    if (!selLink) begin
      // Deselected: idle and silent, any select line pattern works
      l_nxt.st  = SSCP_IDLE;
      l_nxt.drv = 1'b0;
    end else if (start) begin
      // First address bit arrives on the edge that reveals the START
      l_nxt.st  = SSCP_ADDR;
      l_nxt.sh  = byteIn;
      l_nxt.cnt = 3'h1;
      l_nxt.drv = 1'b0;
    end else begin
      unique case (l_r.st)
        SSCP_IDLE: begin
          l_nxt.drv = 1'b0;
        end
        SSCP_ADDR, SSCP_INDEX, SSCP_WDATA: begin
          l_nxt.sh  = byteIn;
          l_nxt.cnt = l_r.cnt + 3'h1;
          if (lastBit) begin
            l_nxt.cnt = '0;
            l_nxt.drv = 1'b1;
            if (l_r.st == SSCP_ADDR) begin
              // Plain 7-bit compare, no other resolution scheme
              if (byteIn[7:1] == l_r.regs[SSCP_IDX_ADDR][7:1]) begin
                l_nxt.rw = byteIn[0];
                l_nxt.st = SSCP_ACK_ADDR;
              end else begin
                l_nxt.drv = 1'b0;
                l_nxt.st  = SSCP_IDLE;
              end
            end else if (l_r.st == SSCP_INDEX) begin
              l_nxt.idx = byteIn;
              l_nxt.st  = SSCP_ACK_IDX;
            end else begin
              l_nxt.st    = SSCP_ACK_WR;
              l_nxt.wrTog = ~l_r.wrTog;
              if (l_r.idx == SSCP_IDX_ADDR) begin
                l_nxt.regs[SSCP_IDX_ADDR] = {byteIn[7:1], 1'b0};
              end else if (l_r.idx == SSCP_IDX_RESET) begin
                if (byteIn[SSCP_BIT_SWRST]) begin
                  // Soft reset spares the address so the device stays reachable
                  l_nxt.regs = defaults(l_r.regs[SSCP_IDX_ADDR]);
                end else begin
                  l_nxt.regs[SSCP_IDX_RESET] = byteIn & SSCP_ANAOFF_MSK;
                end
              end else if (l_r.idx < SSCP_NUM_REGS) begin
                l_nxt.regs[l_r.idx[2:0]] = byteIn;
              end
            end
          end
        end
        SSCP_ACK_ADDR: begin
          l_nxt.cnt = '0;
          if (l_r.rw) begin
            l_nxt.sh  = rdData;
            l_nxt.drv = ~rdData[7];
            l_nxt.st  = SSCP_RDATA;
          end else begin
            l_nxt.drv = 1'b0;
            l_nxt.st  = SSCP_INDEX;
          end
        end
        SSCP_ACK_IDX: begin
          l_nxt.drv = 1'b0;
          l_nxt.st  = SSCP_WDATA;
        end
        SSCP_ACK_WR: begin
          l_nxt.drv = 1'b0;
          l_nxt.st  = SSCP_IDLE;
        end
        SSCP_RDATA: begin
          l_nxt.sh  = {l_r.sh[6:0], 1'b0};
          l_nxt.cnt = l_r.cnt + 3'h1;
          l_nxt.drv = ~l_r.sh[6];
          if (lastBit) begin
            l_nxt.drv = 1'b0;
            l_nxt.st  = SSCP_RACK;
          end
        end
        SSCP_RACK: begin
          // Single-byte reads only; host ack or nack both end the transfer
          l_nxt.drv = 1'b0;
          l_nxt.st  = SSCP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sck) begin
    if (rstLink) begin
      l_r          <= '0;
      l_r.st       <= SSCP_IDLE;
      l_r.prevRise <= 1'b1;
      l_r.regs     <= defaults(SSCP_RST_ADDR);
    end else begin
      l_r <= l_nxt;
    end
  end

  // Data only changes while the clock is low
  always_ff @(negedge sck) begin
    if (rstLink) begin
      sdaOe_r <= 1'b0;
    end else begin
      sdaOe_r <= l_r.drv & selLink;
    end
  end

  always_ff @(negedge sck) begin
    sdaOut <= 1'b0;
  end

  assign sdaOe = sdaOe_r;

  // ****************************************
  // System clock domain
  // ****************************************
  logic      togSys;
  sscp_sys_t s_r;
  sscp_sys_t s_nxt;

  sscp_sync uTogSys (
    .clk (clk),
    .d   (l_r.wrTog),
    .q   (togSys)
  );

  // Registers are stable for many link bits after a toggle, so a bulk copy is safe
  always_comb begin
    s_nxt         = s_r;
    s_nxt.togSeen = togSys;
    if (togSys != s_r.togSeen) begin
      s_nxt.pin0   = (l_r.regs[SSCP_IDX_PIN0][7:4] == SSCP_MODE_GPOUT)
                   & l_r.regs[SSCP_IDX_PINOUT][0];
      s_nxt.pin0Oe = l_r.regs[SSCP_IDX_PIN0][SSCP_BIT_OE];
      s_nxt.anaOff = l_r.regs[SSCP_IDX_RESET][SSCP_BIT_ANAOFF];
      s_nxt.priEn  = l_r.regs[SSCP_IDX_OUTSEL][SSCP_BIT_PRI];
      s_nxt.secEn  = l_r.regs[SSCP_IDX_OUTSEL][SSCP_BIT_SEC];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r        <= '0;
      s_r.pin0Oe <= SSCP_RST_PIN[SSCP_BIT_OE];
      s_r.priEn  <= SSCP_RST_OUTSEL[SSCP_BIT_PRI];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign generalPinZero    = s_r.pin0;
  assign generalPinZeroOe  = s_r.pin0Oe;
  assign analogDisable     = s_r.anaOff;
  assign serOutPrimaryEn   = s_r.priEn;
  assign serOutSecondaryEn = s_r.secEn;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sck); endclocking
  default disable iff (rstLink);

  sequence byteEnd(sscp_state_t s);
    l_r.st == s && lastBit && selLink && !start;
  endsequence

  addr_ack_a: assert property (
    byteEnd(SSCP_ADDR) and (byteIn[7:1] == l_r.regs[0][7:1]) |=> l_r.drv && l_r.st == SSCP_ACK_ADDR)
    else $error("address match not acknowledged");
  addr_miss_a: assert property (
    byteEnd(SSCP_ADDR) and (byteIn[7:1] != l_r.regs[0][7:1]) |=> !l_r.drv && l_r.st == SSCP_IDLE)
    else $error("foreign address acknowledged");
  index_ack_a: assert property (
    byteEnd(SSCP_INDEX) |=> l_r.drv && l_r.idx == $past(byteIn))
    else $error("index byte not acknowledged");
  read_msb_a: assert property (
    l_r.st == SSCP_ACK_ADDR && l_r.rw && selLink && !start |=> l_r.drv == ~$past(rdData[7]))
    else $error("read data not MSB first");
  addr_write_a: assert property (
    byteEnd(SSCP_WDATA) and (l_r.idx == SSCP_IDX_ADDR) |=> l_r.regs[0][7:1] == $past(byteIn[7:1]))
    else $error("address register not written");
  desel_quiet_a: assert property (
    !selLink |=> !l_r.drv && l_r.st == SSCP_IDLE)
    else $error("deselected port active");
  start_decode_a: assert property (
    start && selLink |=> l_r.st == SSCP_ADDR && l_r.cnt == 3'h1)
    else $error("start not decoded");
  write_ack_a: assert property (
    byteEnd(SSCP_WDATA) |=> l_r.drv ##1 !l_r.drv)
    else $error("data byte ack wrong length");

endmodule

/* File: dv/sscp_host.sv */
// Behavioural serial bus host: bit-level clock and open-drain data driver
`timescale 1ns/1ps
module sscp_host (
  output logic      sck,
  output logic      sdaLow,
  input  wire logic sdaIn
);
  // ****************************************
  // Bit timing, 80 ns per bit
  // ****************************************
  // Clock rests low between frames; data released means pulled high
  initial begin
    sck    = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic bitx(input logic b, output logic r);
    sdaLow = ~b;
    #20 sck = 1'b1;
    #20 r = sdaIn;
    #20 sck = 1'b0;
    #20;
  endtask

  task automatic idle(input int n);
    logic r;
    repeat (n) bitx(1'b1, r);
  endtask

  task automatic start();
    sdaLow = 1'b0;
    #20 sck = 1'b1;
    #20 sdaLow = 1'b1;
    #20 sck = 1'b0;
    #20;
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    #20 sck = 1'b1;
    #20 sdaLow = 1'b0;
    #40 sck = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] b, input logic hostAck, output logic [7:0] r,
                      output logic a);
    for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
    bitx(hostAck, a);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] dat,
                    output logic [2:0] acks);
    logic [7:0] r;
    start();
    xfer(adr, 1'b1, r, acks[2]);
    xfer(idx, 1'b1, r, acks[1]);
    xfer(dat, 1'b1, r, acks[0]);
    stop();
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] idx, output logic [7:0] dat,
                    output logic [3:0] acks);
    logic [7:0] r;
    start();
    xfer(adr, 1'b1, r, acks[3]);
    xfer(idx, 1'b1, r, acks[2]);
    start();
    xfer(adr | 8'h01, 1'b1, r, acks[1]);
    xfer(8'hFF, 1'b1, dat, acks[0]);
    stop();
  endtask
endmodule

/* File: dv/smbus_select_config_port_test.sv */
// Self-checking bench for the select-gated configuration port
`timescale 1ns/1ps
module smbus_select_config_port_test
  import sscp_pkg::*;
;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] dat;
    logic [4:0] outs;
  } sscp_row_t;

  // Outputs packed as pin, pin enable, analog off, primary, secondary
  localparam sscp_row_t ROWS [7] = '{
    '{8'h07, 8'h03, 5'h0B}, '{8'h07, 8'h02, 5'h09}, '{8'h07, 8'h01, 5'h0A},
    '{8'h01, 8'h10, 5'h0E}, '{8'h05, 8'h01, 5'h1E}, '{8'h02, 8'h10, 5'h06},
    '{8'h06, 8'h5A, 5'h06}};

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       busSelectIn = 1'b1;
  logic       sck, sdaLow, sdaIn, sdaOut, sdaOe, pz, pzOe, ana, pri, sec;
  logic [4:0] outs;
  int         miscompares = 0;
  int         checked = 0;

  assign sdaIn = !(sdaLow || (sdaOe && !sdaOut));
  assign outs  = {pz, pzOe, ana, pri, sec};

  sscp_port uut (.clk(clk), .rst(rst), .sck(sck), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .busSelectIn(busSelectIn), .generalPinZero(pz),
    .generalPinZeroOe(pzOe), .analogDisable(ana), .serOutPrimaryEn(pri),
    .serOutSecondaryEn(sec));
  sscp_host host (.sck(sck), .sdaLow(sdaLow), .sdaIn(sdaIn));

  always #50 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [2:0] wa;
    logic [3:0] ra;
    logic [7:0] d;
    // Link registers need clock edges while reset is high
    fork
      host.idle(4);
      repeat (4) @(negedge clk);
    join
    rst = 1'b0;
    host.idle(3);
    chk({3'h0, outs}, 8'h0A, "reset outputs");
    host.rd(8'hAE, SSCP_IDX_ADDR, d, ra);
    chk({4'h0, ra}, 8'h01, "read acks");
    chk(d, 8'hAE, "default address");
    foreach (ROWS[i]) begin
      host.wr(8'hAE, ROWS[i].idx, ROWS[i].dat, wa);
      chk({5'h00, wa}, 8'h00, "write acks");
      repeat (8) @(negedge clk);
      chk({3'h0, outs}, {3'h0, ROWS[i].outs}, "outputs");
      host.rd(8'hAE, ROWS[i].idx, d, ra);
      chk(d, ROWS[i].dat, "read back");
    end
    @(negedge clk) busSelectIn = 1'b0;
    host.idle(3);
    host.rd(8'hAE, 8'h06, d, ra);
    chk({4'h0, ra}, 8'h0F, "deselected acks");
    chk(d, 8'hFF, "deselected data");
    host.wr(8'hAE, 8'h07, 8'h03, wa);
    chk({5'h00, wa}, 8'h07, "deselected write acks");
    @(negedge clk) busSelectIn = 1'b1;
    host.idle(3);
    chk({3'h0, outs}, 8'h06, "ignored write");
    host.wr(8'hAE, SSCP_IDX_ADDR, 8'h60, wa);
    chk({5'h00, wa}, 8'h00, "address write acks");
    host.wr(8'hAE, 8'h06, 8'h11, wa);
    chk({5'h00, wa}, 8'h07, "old address");
    host.rd(8'h60, SSCP_IDX_ADDR, d, ra);
    chk(d, 8'h60, "new address");
    host.wr(8'h60, SSCP_IDX_RESET, 8'h01, wa);
    repeat (8) @(negedge clk);
    chk({3'h0, outs}, 8'h0A, "soft reset outputs");
    host.rd(8'h60, 8'h06, d, ra);
    chk(d, 8'h00, "soft reset spare");
    host.rd(8'h60, SSCP_IDX_ADDR, d, ra);
    chk(d, 8'h60, "address kept");
    // ****************************************
    // Mid-run reset and unmapped index
    // ****************************************
    host.wr(8'h60, SSCP_IDX_OUTSEL, 8'h03, wa);
    repeat (8) @(negedge clk);
    chk({3'h0, outs}, 8'h0B, "outputs before reset");
    @(negedge clk) rst = 1'b1;
    fork
      host.idle(4);
      repeat (4) @(negedge clk);
    join
    rst = 1'b0;
    host.idle(3);
    chk({3'h0, outs}, 8'h0A, "mid-run reset outputs");
    host.rd(8'hAE, SSCP_IDX_ADDR, d, ra);
    chk(d, 8'hAE, "address after reset");
    host.wr(8'hAE, 8'h09, 8'h55, wa);
    chk({5'h00, wa}, 8'h00, "unmapped write acks");
    host.rd(8'hAE, 8'h09, d, ra);
    chk(d, 8'h00, "unmapped read");
    end_sim();
  end

  // Whole run is about 83 us of bus traffic
  initial begin
    #500000;
    miscompares++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
endmodule
